/* File: hdl/sec_pkg.sv */
// Shared constants and carrier types for the serial EEPROM host controller.
package sec_pkg;
  localparam int SYS_PERIOD_NS = 10;
  // Half of the serial clock period; the device accepts at most 1 MHz.
  localparam int SCK_HALF_NS = 500;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int PWR_READ_MS = 1;
  localparam int PWR_WRITE_MS = 5;
  localparam int PWR_READ_CYCLES = (PWR_READ_MS * 1000000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int PWR_WRITE_CYCLES = (PWR_WRITE_MS * 1000000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int PWR_CNT_W = 20;

  localparam logic [7:0] OP_LATCH_ENABLE = 8'h06;
  localparam logic [7:0] OP_LATCH_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam int UPPER_ADDRESS_POS = 3;

  localparam int WRITE_BUSY_POS = 0;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'h0c;
  localparam int ARRAY_ADDR_W = 9;
  localparam int PAGE_BYTES = 4;

  localparam int BUS_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_LEN_LSB = 3;
  localparam int CTRL_GO_POS = 7;
  localparam int CTRL_PAUSE_POS = 8;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_RD_READY_POS = 1;
  localparam int STAT_WR_READY_POS = 2;
  localparam int STAT_REFUSED_POS = 3;
  localparam int STAT_DEV_LSB = 8;

  typedef enum logic [2:0] {
    CMD_LATCH_ENABLE = 3'h0,
    CMD_LATCH_DISABLE = 3'h1,
    CMD_READ_STATUS = 3'h2,
    CMD_WRITE_STATUS = 3'h3,
    CMD_READ = 3'h4,
    CMD_WRITE = 3'h5
  } sec_cmd_t;

  typedef struct packed {
    logic [BUS_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sec_bus_t;

  typedef struct packed {
    logic chip_select_n;
    logic serial_clock;
    logic serial_in;
    logic pause_n;
  } sec_pins_t;
endpackage : sec_pkg

/* File: hdl/sec_tick.sv */
// Enable pulse divider that paces each half period of the serial clock.
module sec_tick #(
  parameter int HALF = 50
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic run,
  output logic tick
);
  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // Stopping clears the count, so every resumed half period is full length.
  always_comb begin
    cnt_next = cnt_reg;
    if (!run || cnt_reg == LAST) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = run && (cnt_reg == LAST);
endmodule : sec_tick

/* File: hdl/sec_shift.sv */
// Shift register that sends its top bit out and takes a sampled bit in.
module sec_shift #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic shift,
  input wire logic in_bit,
  output logic [WIDTH-1:0] data
);
  logic [WIDTH-1:0] data_reg;
  logic [WIDTH-1:0] data_next;

  always_comb begin
    data_next = data_reg;
    if (load) begin
      data_next = load_val;
    end else if (shift) begin
      data_next = {data_reg[WIDTH-2:0], in_bit};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      data_reg <= '0;
    end else begin
      data_reg <= data_next;
    end
  end

  assign data = data_reg;
endmodule : sec_shift

/* File: hdl/sec_host.sv */
// Host controller that drives the serial EEPROM through its four link pins.
// Notes on behaviour
// (R1) Read sends opcode, then low address byte.
// (R2) Ninth address bit rides opcode bit three.
// (R3) Device returns addressed byte after address.
// (R4) Device auto-increments, wrapping top to zero.
// (R5) Chip select high ends every read.
// (R6) Status opcode returns one status byte.
// (R7) Latch enable goes in its own frame.
// (R8) Write in latch-enable frame is ignored.
// (R9) Array write: opcode, address, data bytes.
// (R10) One to four bytes, one page.
// (R11) Device wraps write address inside page.
// (R12) Chip select rises only after whole byte.
// (R13) Status write sends only protect bits.
// (R14) Status reads report busy during write.
// (R15) Pause pin changes only while clock low.
// (R16) Device powers up idle, latch cleared.
// (R17) First chip select fall activates device.
// (R18) Wait power-up delays before reads, writes.
// (R19) Opcode values, ninth address in opcode.
// (R20) Status: busy, latch, two protect bits.
// (R21) Protect bits guard quarter, half, all.
// (R22) Device clears latch after disable, writes.
// (R23) Device drops protected or unlatched writes.
// (R24) Sample rising edge, MSB first, mode zero.
module sec_host #(
  parameter int PWR_READ_CYCLES = sec_pkg::PWR_READ_CYCLES,
  parameter int PWR_WRITE_CYCLES = sec_pkg::PWR_WRITE_CYCLES,
  parameter int SCK_HALF = sec_pkg::SCK_HALF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire sec_pkg::sec_bus_t bus,
  output logic [31:0] rdata,
  output sec_pkg::sec_pins_t pins,
  input wire logic serial_out
);
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LO, ST_HI, ST_LAG, ST_GAP} sec_state_t;
  typedef enum logic [1:0] {PH_LATCH, PH_MAIN, PH_POLL} sec_phase_t;
  localparam logic [sec_pkg::PWR_CNT_W-1:0] RD_WAIT = sec_pkg::PWR_CNT_W'(PWR_READ_CYCLES);
  localparam logic [sec_pkg::PWR_CNT_W-1:0] WR_WAIT = sec_pkg::PWR_CNT_W'(PWR_WRITE_CYCLES);
  localparam logic [2:0] PAGE = 3'(sec_pkg::PAGE_BYTES);
  sec_state_t state_reg, state_next;
  sec_phase_t phase_reg, phase_next;
  sec_pkg::sec_cmd_t cmd_reg, cmd_next;
  logic [2:0] bit_reg, bit_next, byte_reg, byte_next, count_reg, count_next;
  logic cs_n_reg, cs_n_next, sck_reg, sck_next, pause_n_reg, pause_n_next;
  logic pause_req_reg, pause_req_next, refused_reg, refused_next, so_s1_reg, so_s2_reg;
  logic [1:0] len_reg, len_next;
  logic [sec_pkg::ARRAY_ADDR_W-1:0] addr_reg, addr_next;
  logic [31:0] wdata_reg, wdata_next, rdbuf_reg, rdbuf_next, rdata_reg, rdata_next;
  logic [7:0] stat_reg, stat_next;
  logic [sec_pkg::PWR_CNT_W-1:0] pwr_reg, pwr_next;
  logic tick, run, load, shift, rd_ready, wr_ready, busy, go, needs_write, start_ok;
  logic [7:0] tx_byte, shift_q, rx_byte, main_op;
  logic [2:0] byte_sel, total, room, req_len;
  sec_pkg::sec_cmd_t go_cmd;
  assign busy = (state_reg != ST_IDLE);
  // (R18) Power-up readiness gates.
  assign rd_ready = (pwr_reg >= RD_WAIT);
  assign wr_ready = (pwr_reg >= WR_WAIT);
  assign go = bus.wr && (bus.addr == sec_pkg::REG_CTRL) && bus.wdata[sec_pkg::CTRL_GO_POS];
  assign go_cmd = sec_pkg::sec_cmd_t'(bus.wdata[sec_pkg::CTRL_CMD_LSB +: 3]);
  assign needs_write = (go_cmd == sec_pkg::CMD_WRITE) || (go_cmd == sec_pkg::CMD_WRITE_STATUS);
  assign start_ok = go && !busy && (needs_write ? wr_ready : rd_ready) &&
                    (go_cmd <= sec_pkg::CMD_WRITE);
  // (R10) Clamp byte count to page end.
  assign room = PAGE - {1'b0, addr_reg[1:0]};
  assign req_len = {1'b0, bus.wdata[sec_pkg::CTRL_LEN_LSB +: 2]} + 3'd1;
  // A pause lets a high phase finish, so the pause pin only moves with the clock low.
  assign run = busy && pause_n_reg && !(pause_req_reg && !sck_reg);
  assign rx_byte = {shift_q[6:0], so_s2_reg};
  assign byte_sel = (state_reg == ST_HI) ? byte_reg + 3'd1 : byte_reg;
  // (R19) Opcode encoding.
  always_comb begin
    case (cmd_reg)
      sec_pkg::CMD_LATCH_ENABLE: main_op = sec_pkg::OP_LATCH_ENABLE;
      sec_pkg::CMD_LATCH_DISABLE: main_op = sec_pkg::OP_LATCH_DISABLE;
      sec_pkg::CMD_WRITE_STATUS: main_op = sec_pkg::OP_WRITE_STATUS;
      sec_pkg::CMD_READ: main_op = sec_pkg::OP_READ;
      sec_pkg::CMD_WRITE: main_op = sec_pkg::OP_WRITE;
      default: main_op = sec_pkg::OP_READ_STATUS;
    endcase
    // (R2) Ninth address bit in opcode.
    if (cmd_reg == sec_pkg::CMD_READ || cmd_reg == sec_pkg::CMD_WRITE) begin
      main_op[sec_pkg::UPPER_ADDRESS_POS] = addr_reg[8];
    end
  end
  // Frame contents per phase; receive slots are sent as zero, except the status read command, which sends the low address byte.
  always_comb begin
    total = 3'd1;
    tx_byte = 8'h00;
    case (phase_reg)
      // (R7) Latch enable alone in its frame.
      PH_LATCH: tx_byte = sec_pkg::OP_LATCH_ENABLE;
      // (R14) Poll status during write cycle.
      PH_POLL: begin
        total = 3'd2;
        if (byte_sel == 3'd0) begin
          tx_byte = sec_pkg::OP_READ_STATUS;
        end
      end
      default: begin
        case (cmd_reg)
          sec_pkg::CMD_READ_STATUS: total = 3'd2;
          sec_pkg::CMD_WRITE_STATUS: total = 3'd2;
          // (R1) Opcode, address, then data.
          sec_pkg::CMD_READ: total = 3'd2 + count_reg;
          // (R9) At least one data byte.
          sec_pkg::CMD_WRITE: total = 3'd2 + count_reg;
          default: total = 3'd1;
        endcase
        if (byte_sel == 3'd0) begin
          tx_byte = main_op;
        end else if (byte_sel == 3'd1) begin
          if (cmd_reg == sec_pkg::CMD_WRITE_STATUS) begin
            // (R13) Only protect bits may be one.
            tx_byte = wdata_reg[7:0] & sec_pkg::STATUS_WRITE_MASK;
          end else begin
            tx_byte = addr_reg[7:0];
          end
        end else if (cmd_reg == sec_pkg::CMD_WRITE) begin
          tx_byte = wdata_reg[{byte_sel[1:0] - 2'd2, 3'b000} +: 8];
        end
      end
    endcase
  end
  // Link engine and command intake.
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cmd_next = cmd_reg;
    bit_next = bit_reg;
    byte_next = byte_reg;
    count_next = count_reg;
    cs_n_next = cs_n_reg;
    sck_next = sck_reg;
    len_next = len_reg;
    refused_next = refused_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdbuf_next = rdbuf_reg;
    stat_next = stat_reg;
    load = 1'b0;
    shift = 1'b0;
    pwr_next = wr_ready ? pwr_reg : pwr_reg + sec_pkg::PWR_CNT_W'(1);
    pause_req_next = pause_req_reg;
    pause_n_next = pause_n_reg;
    if (bus.wr && bus.addr == sec_pkg::REG_CTRL) begin
      pause_req_next = bus.wdata[sec_pkg::CTRL_PAUSE_POS];
    end
    // (R15) Pause pin moves only with clock low.
    if (!sck_reg) begin
      pause_n_next = !pause_req_reg;
    end
    if (!busy && bus.wr && bus.addr == sec_pkg::REG_ADDR) begin
      addr_next = bus.wdata[sec_pkg::ARRAY_ADDR_W-1:0];
    end
    if (!busy && bus.wr && bus.addr == sec_pkg::REG_WDATA) begin
      wdata_next = bus.wdata;
    end
    if (go) begin
      refused_next = !start_ok;
    end
    case (state_reg)
      ST_IDLE: begin
        if (start_ok) begin
          cmd_next = go_cmd;
          len_next = bus.wdata[sec_pkg::CTRL_LEN_LSB +: 2];
          count_next = (go_cmd == sec_pkg::CMD_WRITE && req_len > room) ? room : req_len;
          phase_next = needs_write ? PH_LATCH : PH_MAIN;
          // (R17) Every frame opens with a fall.
          cs_n_next = 1'b0;
          byte_next = 3'd0;
          bit_next = 3'd0;
          state_next = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (tick) begin
          load = 1'b1;
          state_next = ST_LO;
        end
      end
      ST_LO: begin
        if (tick) begin
          sck_next = 1'b1;
          state_next = ST_HI;
        end
      end
      ST_HI: begin
        if (tick) begin
          // (R24) Sample before falling edge.
          sck_next = 1'b0;
          state_next = ST_LO;
          if (bit_reg == 3'd7) begin
            bit_next = 3'd0;
            // (R6) Capture returned status byte.
            if (byte_reg == 3'd1 && (phase_reg == PH_POLL ||
                cmd_reg == sec_pkg::CMD_READ_STATUS)) begin
              stat_next = rx_byte;
            end
            // (R3) Capture returned array bytes.
            if (phase_reg == PH_MAIN && cmd_reg == sec_pkg::CMD_READ && byte_reg >= 3'd2) begin
              rdbuf_next[{byte_reg[1:0] - 2'd2, 3'b000} +: 8] = rx_byte;
            end
            // (R12) End only on a byte boundary.
            if (byte_reg == total - 3'd1) begin
              state_next = ST_LAG;
            end else begin
              byte_next = byte_reg + 3'd1;
              load = 1'b1;
            end
          end else begin
            shift = 1'b1;
            bit_next = bit_reg + 3'd1;
          end
        end
      end
      ST_LAG: begin
        if (tick) begin
          // (R5) Chip select high ends frame.
          cs_n_next = 1'b1;
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tick) begin
          byte_next = 3'd0;
          bit_next = 3'd0;
          if (phase_reg == PH_LATCH) begin
            phase_next = PH_MAIN;
            cs_n_next = 1'b0;
            state_next = ST_LEAD;
          end else if ((phase_reg == PH_MAIN && (cmd_reg == sec_pkg::CMD_WRITE ||
                       cmd_reg == sec_pkg::CMD_WRITE_STATUS)) ||
                       (phase_reg == PH_POLL && stat_reg[sec_pkg::WRITE_BUSY_POS])) begin
            // (R20) Busy flag decides further polling.
            phase_next = PH_POLL;
            cs_n_next = 1'b0;
            state_next = ST_LEAD;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end
  // Register read mux; data appear one cycle after the strobe.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        sec_pkg::REG_CTRL: begin
          rdata_next[sec_pkg::CTRL_CMD_LSB +: 3] = cmd_reg;
          rdata_next[sec_pkg::CTRL_LEN_LSB +: 2] = len_reg;
          rdata_next[sec_pkg::CTRL_PAUSE_POS] = pause_req_reg;
        end
        sec_pkg::REG_ADDR: rdata_next[sec_pkg::ARRAY_ADDR_W-1:0] = addr_reg;
        sec_pkg::REG_WDATA: rdata_next = wdata_reg;
        sec_pkg::REG_RDATA: rdata_next = rdbuf_reg;
        sec_pkg::REG_STATUS: begin
          rdata_next[sec_pkg::STAT_BUSY_POS] = busy;
          rdata_next[sec_pkg::STAT_RD_READY_POS] = rd_ready;
          rdata_next[sec_pkg::STAT_WR_READY_POS] = wr_ready;
          rdata_next[sec_pkg::STAT_REFUSED_POS] = refused_reg;
          rdata_next[sec_pkg::STAT_DEV_LSB +: 8] = stat_reg;
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_MAIN;
      cmd_reg <= sec_pkg::CMD_LATCH_ENABLE;
      bit_reg <= 3'd0;
      byte_reg <= 3'd0;
      count_reg <= 3'd1;
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
      pause_n_reg <= 1'b1;
      pause_req_reg <= 1'b0;
      len_reg <= 2'd0;
      refused_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      rdbuf_reg <= 32'h0000_0000;
      stat_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
      pwr_reg <= '0;
      so_s1_reg <= 1'b0;
      so_s2_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cmd_reg <= cmd_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      count_reg <= count_next;
      cs_n_reg <= cs_n_next;
      sck_reg <= sck_next;
      pause_n_reg <= pause_n_next;
      pause_req_reg <= pause_req_next;
      len_reg <= len_next;
      refused_reg <= refused_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdbuf_reg <= rdbuf_next;
      stat_reg <= stat_next;
      rdata_reg <= rdata_next;
      pwr_reg <= pwr_next;
      so_s1_reg <= serial_out;
      so_s2_reg <= so_s1_reg;
    end
  end
  sec_tick #(.HALF(SCK_HALF)) u_tick (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(run),
    .tick(tick)
  );
  // (R24) Most significant bit leaves first.
  sec_shift #(.WIDTH(8)) u_shift (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .load(load),
    .load_val(tx_byte),
    .shift(shift),
    .in_bit(so_s2_reg),
    .data(shift_q)
  );
  assign rdata = rdata_reg;
  assign pins = {cs_n_reg, sck_reg, shift_q[7], pause_n_reg};
endmodule : sec_host

/* File: dv/sec_host_props.sv */
// Link checks for the serial EEPROM host controller.
module sec_host_props #(
  parameter int PWR_READ_CYCLES = 100000,
  parameter int PWR_WRITE_CYCLES = 500000,
  parameter int SCK_HALF = 50
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire sec_pkg::sec_bus_t bus,
  input wire logic [31:0] rdata,
  input wire sec_pkg::sec_pins_t pins,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sck_q;
  logic [7:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] op_reg;
  logic [7:0] last_op;
  logic [7:0] addr_lo;
  int up_cnt;
  // Bits are counted on the host's own serial clock rises inside a frame.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sck_q <= 1'b0;
      bit_cnt <= 8'h00;
      shreg <= 8'h00;
      op_reg <= 8'h00;
      last_op <= 8'h00;
      addr_lo <= 8'h00;
      up_cnt <= 0;
    end else begin
      sck_q <= pins.serial_clock;
      up_cnt <= (up_cnt < PWR_WRITE_CYCLES) ? up_cnt + 1 : up_cnt;
      if (pins.chip_select_n) begin
        bit_cnt <= 8'h00;
      end else if (pins.serial_clock && !sck_q) begin
        bit_cnt <= bit_cnt + 8'h01;
        shreg <= {shreg[6:0], pins.serial_in};
        if (bit_cnt == 8'h07) begin
          last_op <= op_reg;
          op_reg <= {shreg[6:0], pins.serial_in};
        end
        if (bit_cnt == 8'h0f) begin
          addr_lo <= {shreg[6:0], pins.serial_in};
        end
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_op_in;
    $rose(bit_cnt == 8'h08);
  endsequence
  property p_pause_edge;
    $changed(pins.pause_n) |-> !pins.serial_clock && !$past(pins.serial_clock);
  endproperty
  a_pause_edge: assert property (p_pause_edge) else $error("pause moved with clock high");
  property p_si_hold;
    pins.serial_clock |-> $stable(pins.serial_in);
  endproperty
  a_si_hold: assert property (p_si_hold) else $error("serial_in moved in high phase");
  property p_cs_byte;
    $rose(pins.chip_select_n) |-> !pins.serial_clock && bit_cnt[2:0] == 3'h0 && bit_cnt != 8'h00;
  endproperty
  a_cs_byte: assert property (p_cs_byte) else $error("frame ended off a byte");
  property p_opcode;
    s_op_in |-> ((op_reg & 8'hf7) inside {8'h02, 8'h03}) ||
                (op_reg inside {8'h01, 8'h04, 8'h05, 8'h06});
  endproperty
  a_opcode: assert property (p_opcode) else $error("unknown opcode sent");
  property p_latch_first;
    s_op_in ##0 ((op_reg & 8'hf7) == 8'h02 || op_reg == 8'h01) |-> last_op == 8'h06;
  endproperty
  a_latch_first: assert property (p_latch_first) else $error("write without enable frame");
  property p_status_mask;
    $rose(bit_cnt == 8'h10) && op_reg == 8'h01 |-> (shreg & 8'hf3) == 8'h00;
  endproperty
  a_status_mask: assert property (p_status_mask) else $error("status byte has stray bits");
  property p_page;
    $rose(pins.chip_select_n) && (op_reg & 8'hf7) == 8'h02 |->
      int'(bit_cnt) <= 48 - 8 * int'(addr_lo[1:0]);
  endproperty
  a_page: assert property (p_page) else $error("write crossed a page");
  property p_power;
    s_op_in |-> up_cnt >= (((op_reg & 8'hf7) == 8'h02 || op_reg == 8'h01) ?
                           PWR_WRITE_CYCLES : PWR_READ_CYCLES);
  endproperty
  a_power: assert property (p_power) else $error("command before power-up delay");
  // Read data stand only in the cycle after a read strobe.
  property p_rdata_idle;
    !$past(bus.rd) |-> rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside their cycle");
endmodule : sec_host_props
bind sec_host sec_host_props #(.PWR_READ_CYCLES(PWR_READ_CYCLES), .PWR_WRITE_CYCLES(PWR_WRITE_CYCLES),
  .SCK_HALF(SCK_HALF)) u_props (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
  .pins(pins), .serial_out(serial_out));

/* File: dv/sec_dev_model.sv */
// Behavioural serial EEPROM that answers the host controller's frames.
module sec_dev_model #(
  parameter int BUSY_NS = 3000
) (
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic pause_n,
  output logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [512];
  logic [7:0] op = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [8:0] addr = 9'h000;
  logic [9:0] lim;
  logic [1:0] prot = 2'h0;
  logic active = 1'b0;
  logic so_q = 1'b0;
  int nbits = 0;
  realtime busy_end = 0;
  logic [8:0] qa[$];
  logic [7:0] qd[$];
  logic latch = 1'b0;
  initial for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'h5a ^ {i[8], 7'h0};
  // Released line shows the inverse, so a stale value never passes.
  assign serial_out = (chip_select_n || !active) ? ~so_q : so_q;
  always @(negedge chip_select_n) begin
    active = 1'b1;
    nbits = 0;
    op = 8'h00;
    qa.delete();
    qd.delete();
  end
  always @(posedge serial_clock) begin
    if (!chip_select_n && pause_n && active) begin
      sh = {sh[6:0], serial_in};
      nbits++;
      if (nbits == 8) op = sh;
      if (nbits % 8 == 0 && op == 8'h05) begin
        tx = ($realtime < busy_end) ? 8'hff : {4'h0, prot, latch, 1'b0};
      end
      if (nbits >= 16 && nbits % 8 == 0 && (op & 8'hf7) == 8'h03) begin
        if (nbits == 16) addr = {op[3], sh};
        tx = mem[addr];
        addr = addr + 9'h001;
      end
      if (nbits >= 16 && nbits % 8 == 0 && (op & 8'hf7) == 8'h02) begin
        if (nbits == 16) addr = {op[3], sh};
        if (nbits > 16) begin
          qa.push_back(addr);
          qd.push_back(sh);
          addr = {addr[8:2], addr[1:0] + 2'h1};
        end
      end
    end
  end
  always @(negedge serial_clock) begin
    if (!chip_select_n && pause_n && active) begin
      so_q = tx[7];
      tx = {tx[6:0], 1'b0};
    end
  end
  always @(posedge chip_select_n) begin
    if (active && $realtime >= busy_end) begin
      if (nbits == 8 && op == 8'h06) latch = 1'b1;
      if (nbits == 8 && op == 8'h04) latch = 1'b0;
      if (nbits == 16 && op == 8'h01 && latch) begin
        prot = sh[3:2];
        latch = 1'b0;
        busy_end = $realtime + BUSY_NS;
      end
      if (nbits >= 24 && nbits % 8 == 0 && (op & 8'hf7) == 8'h02 && latch) begin
        lim = (prot == 2'h0) ? 10'h200 : (prot == 2'h1) ? 10'h180 :
              (prot == 2'h2) ? 10'h100 : 10'h000;
        foreach (qa[k]) if ({1'b0, qa[k]} < lim) mem[qa[k]] = qd[k];
        latch = 1'b0;
        busy_end = $realtime + BUSY_NS;
      end
    end
  end
endmodule : sec_dev_model

/* File: dv/tb_top.sv */
// Register-level bench for the serial EEPROM host controller.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk;
  logic resetn;
  sec_pkg::sec_bus_t bus;
  logic [31:0] rdata;
  sec_pkg::sec_pins_t pins;
  logic serial_out;
  logic [31:0] got;
  int num_errors = 0;
  int compares = 0;
  sec_host #(.PWR_READ_CYCLES(20), .PWR_WRITE_CYCLES(40), .SCK_HALF(4)) dut (.sys_clk(sys_clk),
    .resetn(resetn), .bus(bus), .rdata(rdata), .pins(pins), .serial_out(serial_out));
  sec_dev_model #(.BUSY_NS(3000)) model (.chip_select_n(pins.chip_select_n),
    .serial_clock(pins.serial_clock), .serial_in(pins.serial_in), .pause_n(pins.pause_n),
    .serial_out(serial_out));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 got = rdata;
    @(posedge sys_clk);
  endtask : rd
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // Polls the busy bit with a bound; a hang counts as a mismatch.
  task automatic wait_idle();
    int n;
    n = 0;
    got = 32'h1;
    while (got[0] !== 1'b0 && n < 3000) begin
      rd(sec_pkg::REG_STATUS);
      n++;
    end
    if (n >= 3000) begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_idle
  task automatic run(input logic [2:0] cmd, input logic [1:0] len);
    wr(sec_pkg::REG_CTRL, {23'h0, 1'b0, 1'b1, 2'h0, len, cmd});
    wait_idle();
  endtask : run
  function automatic logic [7:0] fill(input logic [8:0] a);
    return a[7:0] ^ 8'h5a ^ {a[8], 7'h0};
  endfunction : fill
  initial begin
    resetn = 1'b0;
    bus = '0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    run(sec_pkg::CMD_READ, 2'h0);
    check(got & 32'h0f, 32'h08);
    repeat (40) @(posedge sys_clk);
    run(sec_pkg::CMD_READ_STATUS, 2'h0);
    check(got & 32'hff0f, 32'h0006);
    wr(sec_pkg::REG_ADDR, 32'h1fe);
    wr(sec_pkg::REG_WDATA, 32'h44332211);
    run(sec_pkg::CMD_WRITE, 2'h3);
    check(got & 32'hff01, 32'h0);
    wr(sec_pkg::REG_ADDR, 32'h1fe);
    run(sec_pkg::CMD_READ, 2'h3);
    rd(sec_pkg::REG_RDATA);
    check(got, {fill(9'h001), fill(9'h000), 8'h22, 8'h11});
    run(sec_pkg::CMD_LATCH_ENABLE, 2'h0);
    run(sec_pkg::CMD_READ_STATUS, 2'h0);
    check(got & 32'hff00, 32'h0200);
    run(sec_pkg::CMD_LATCH_DISABLE, 2'h0);
    run(sec_pkg::CMD_READ_STATUS, 2'h0);
    check(got & 32'hff00, 32'h0);
    wr(sec_pkg::REG_WDATA, 32'hff);
    run(sec_pkg::CMD_WRITE_STATUS, 2'h0);
    run(sec_pkg::CMD_READ_STATUS, 2'h0);
    check(got & 32'hff00, 32'h0c00);
    wr(sec_pkg::REG_ADDR, 32'h010);
    wr(sec_pkg::REG_WDATA, 32'haa);
    run(sec_pkg::CMD_WRITE, 2'h0);
    run(sec_pkg::CMD_READ, 2'h0);
    rd(sec_pkg::REG_RDATA);
    check(got & 32'hff, {24'h0, fill(9'h010)});
    run(3'h6, 2'h0);
    check(got & 32'h0f, 32'h0e);
    // The read crosses the ninth address bit while paused in mid-byte.
    wr(sec_pkg::REG_ADDR, 32'h0ff);
    wr(sec_pkg::REG_CTRL, 32'h9c);
    repeat (100) @(posedge sys_clk);
    wr(sec_pkg::REG_CTRL, 32'h11c);
    repeat (200) @(posedge sys_clk);
    check({31'h0, pins.pause_n}, 32'h0);
    rd(sec_pkg::REG_CTRL);
    check(got, 32'h0000_011c);
    wr(sec_pkg::REG_CTRL, 32'h01c);
    wait_idle();
    rd(sec_pkg::REG_RDATA);
    check(got, {fill(9'h102), fill(9'h101), fill(9'h100), fill(9'h0ff)});
    rd(8'h14);
    check(got, 32'h0);
    wrap_up();
  end
endmodule : tb_top
